// [hdl/synth_prog_regs.svh]
// Register offsets, field positions, reset values and table constants of the programming block.
`ifndef SYNTH_PROG_REGS_SVH
`define SYNTH_PROG_REGS_SVH
`define REG_FREQ_A_OFS   8'h00
`define REG_FREQ_B_OFS   8'h04
`define REG_STATUS_OFS   8'h08
`define REG_CTRL_OFS     8'h0c
`define SHIFT_LEN        24
`define WORD_LSB         2
`define FREQ_A_FIELD_LSB 5
`define FREQ_RESET       22'h000000
`define REF_RESET        16'h0008
`define CTRL_PD_BIT      0
`define CP1_UA_G00       8'h32
`define CP1_UA_G10       8'h4b
`define CP1_UA_G01       8'h7d
`define CP1_UA_G11       8'hc8
`define CP2_X2_G00       3'h2
`define CP2_X2_G10       3'h3
`define CP2_X2_G01       3'h5
`define CP2_X2_G11       3'h0
`endif

// [hdl/synth_prog_pkg.sv]
// Types shared by the serial programming and phase detector control block.
package synth_prog_pkg;
  // Serial link framing states, one-hot.
  typedef enum logic [1:0] {
    LINK_IDLE  = 2'b01,
    LINK_FRAME = 2'b10
  } link_state_t;
  // One frequency word: 15-bit M count, 4-bit A count, gain pair, sense bit.
  typedef struct packed {
    logic [14:0] m_count;
    logic [3:0]  a_count;
    logic        gain_sel_hi;
    logic        gain_sel_lo;
    logic        sense;
  } freq_word_t;
  // Reference word: ratio, two phase detector control bits, prescaler pair.
  typedef struct packed {
    logic [12:0] ref_ratio;
    logic        comp_output_enable;
    logic        lock_gate_enable;
    logic        prescaler_low;
  } ref_word_t;
  // Charge pump controls. Multiplier is in halves; code 0 stands for x4 (eight halves).
  typedef struct packed {
    logic       cp1_on;
    logic       cp2_on;
    logic       pump_source;
    logic [7:0] cp1_current_ua;
    logic [2:0] cp2_mult_x2;
  } pump_ctrl_t;
  // Whole state of the main block.
  typedef struct packed {
    link_state_t link;
    logic [23:0] shift;
    logic [4:0]  bit_cnt;
    logic        clk_prev;
    logic        ref_prev;
    logic        rf_prev;
    freq_word_t  word_a;
    freq_word_t  word_b;
    ref_word_t   refw;
    logic [3:0]  swallow;
    logic [7:0]  load_cnt;
    logic        power_down;
    logic        ack;
    logic [31:0] rdata;
    logic [14:0] m_out;
    logic [3:0]  a_out;
    pump_ctrl_t  pump;
    logic        lock_n;
    logic        rf_pin;
    logic        ref_pin;
    logic        presc_out;
  } core_state_t;
endpackage

// [hdl/pin_sync.sv]
// Two flip-flop synchroniser for a bundle of asynchronous pins.
`timescale 1ns/100ps
`default_nettype none
module pin_sync #(
  parameter int WIDTH = 7
) (
  input  wire logic             sys_clk,
  input  wire logic             reset,
  input  wire logic [WIDTH-1:0] pins_async,
  output logic      [WIDTH-1:0] pins_sync
);
  // First stage feeds only the second stage.
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } sync_state_t;
  sync_state_t s_ff;
  sync_state_t nxt_s;

  // Next value: shift the pins through two stages.
  always_comb begin
    nxt_s.meta   = pins_async;
    nxt_s.stable = s_ff.meta;
  end

  // State register.
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign pins_sync = s_ff.stable;
endmodule
`default_nettype wire

// [hdl/ref_divider.sv]
// Programmable reference divider counting reference ticks.
`timescale 1ns/100ps
`default_nettype none
module ref_divider #(
  parameter int RATIO_W = 13
) (
  input  wire logic               sys_clk,
  input  wire logic               reset,
  input  wire logic               tick,
  input  wire logic [RATIO_W-1:0] ratio,
  output logic                    div_pulse
);
  typedef struct packed {
    logic [RATIO_W-1:0] cnt;
    logic               pulse;
  } div_state_t;
  div_state_t s_ff;
  div_state_t nxt_s;
  logic       wrap;

  // Wrap when the count reaches the ratio; ratio 0 acts as 1, and a ratio lowered
  // below the running count wraps at once rather than running out to 8191.
  always_comb begin
    nxt_s       = s_ff;
    nxt_s.pulse = 1'b0;
    wrap        = (RATIO_W'(s_ff.cnt + 1'b1) >= ratio);
    if (tick) begin
      if (wrap) begin
        nxt_s.cnt   = '0;
        nxt_s.pulse = 1'b1;
      end else begin
        nxt_s.cnt = RATIO_W'(s_ff.cnt + 1'b1);
      end
    end
  end

  // State register.
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign div_pulse = s_ff.pulse;

  property p_ratio_one;
    @(posedge sys_clk) disable iff (reset)
    (tick && ratio <= RATIO_W'(1)) |=> div_pulse;
  endproperty
  a_ratio_one: assert property (p_ratio_one) else $error("Ratio one must pass every tick.");
endmodule
`default_nettype wire

// [hdl/synth_prog.sv]
// Serial programming, word buffers and phase detector control of the synthesiser.
`timescale 1ns/100ps
`default_nettype none
`include "synth_prog_regs.svh"
module synth_prog
  import synth_prog_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        reset,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        ser_data,
  input  wire logic        ser_clk,
  input  wire logic        ser_enable,
  input  wire logic        freq_word_select,
  input  wire logic        lock_window,
  input  wire logic        ref_osc,
  input  wire logic        rf_div_in,
  output logic      [14:0] m_count,
  output logic      [3:0]  a_count,
  output logic      [3:0]  swallow_count_bits,
  output logic             prescaler_low,
  output pump_ctrl_t       pump,
  output logic             lock_indicator_n,
  output logic             rf_divider_out,
  output logic             ref_divider_out
);
  logic [6:0]  pins_s;      // Synchronised pins.
  logic        data_s;      // Serial data after synchronising.
  logic        clk_s;       // Serial clock after synchronising.
  logic        en_s;        // Serial enable after synchronising.
  logic        sel_s;       // Frequency word select after synchronising.
  logic        lock_s;      // Lock window comparator after synchronising.
  logic        ref_tick;    // One-cycle pulse per reference oscillator rise.
  logic        rf_tick;     // One-cycle pulse per RF divider rise.
  logic        ref_div;     // Reference divider output pulse.
  logic        clk_rise;    // Serial clock rising edge seen this cycle.
  logic        frame_end;   // Enable fell: the frame closes now.
  logic [1:0]  dest;        // Destination code {dest_code_hi, dest_code_lo}.
  logic        wb_req;      // Bus request present.
  logic        wb_wr;       // Write takes effect this cycle.
  logic        comp_en;     // Comparison outputs allowed.
  freq_word_t  active;      // Word steering dividers and phase detector.
  logic [31:0] rd_mux;      // Read data before registering.
  core_state_t s_ff;        // Whole state.
  core_state_t nxt_s;       // Next state.

  // All pins come from outside the clock domain, so each passes two flops.
  // The pins share one synchroniser, so data and clock keep their relative skew.
  pin_sync #(
    .WIDTH (7)
  ) u_sync (
    .sys_clk    (sys_clk),
    .reset      (reset),
    .pins_async ({rf_div_in, ref_osc, lock_window, freq_word_select,
                  ser_enable, ser_clk, ser_data}),
    .pins_sync  (pins_s)
  );

  assign data_s = pins_s[0];
  assign clk_s  = pins_s[1];
  assign en_s   = pins_s[2];
  assign sel_s  = pins_s[3];
  assign lock_s = pins_s[4];

  // Edges are found on the synchronised copies only.
  // Reading the first stage here would let a metastable level reach the logic.
  assign ref_tick = pins_s[5] & ~s_ff.ref_prev;
  assign rf_tick  = pins_s[6] & ~s_ff.rf_prev;

  // Reference divider follows the reference word's ratio.
  // A new ratio takes effect at the next reference tick, with no restart.
  ref_divider #(
    .RATIO_W (13)
  ) u_refdiv (
    .sys_clk   (sys_clk),
    .reset     (reset),
    .tick      (ref_tick),
    .ratio     (s_ff.refw.ref_ratio),
    .div_pulse (ref_div)
  );

  // Data and clock share one synchroniser depth, so their skew is preserved.
  assign clk_rise  = clk_s & ~s_ff.clk_prev & en_s;
  assign frame_end = (s_ff.link == LINK_FRAME) & ~en_s;
  assign dest      = s_ff.shift[1:0];
  assign wb_req    = wb_cyc_i & wb_stb_i;
  assign wb_wr     = wb_req & s_ff.ack & wb_we_i;
  assign active    = sel_s ? s_ff.word_a : s_ff.word_b;
  assign comp_en   = s_ff.refw.comp_output_enable & ~s_ff.power_down;

  // Read multiplexer; unmapped offsets read as zero.
  // The address is decoded whole, so aliases of a register read zero too.
  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (wb_adr_i)
      `REG_FREQ_A_OFS: rd_mux = {10'h000, s_ff.word_a};
      `REG_FREQ_B_OFS: rd_mux = {10'h000, s_ff.word_b};
      `REG_STATUS_OFS: rd_mux = {s_ff.load_cnt, 1'b0, s_ff.link == LINK_FRAME,
                                 lock_s, sel_s, s_ff.swallow, s_ff.refw};
      `REG_CTRL_OFS:   rd_mux = {31'h0000_0000, s_ff.power_down};
      default:         rd_mux = 32'h0000_0000;
    endcase
  end

  // Next state of link, buffers, bus slave and registered outputs.
  always_comb begin
    nxt_s          = s_ff;
    nxt_s.clk_prev = clk_s;
    nxt_s.ref_prev = pins_s[5];
    nxt_s.rf_prev  = pins_s[6];

    // Link framing: the shift register fills only inside an enable frame.
    // Loads ignore power-down: this path stays alive while the rest sleeps.
    unique case (s_ff.link)
      LINK_IDLE: begin
        // The bit count restarts with each frame, so no frame inherits an old count.
        if (en_s) begin
          nxt_s.link    = LINK_FRAME;
          nxt_s.bit_cnt = 5'h00;
        end
      end
      LINK_FRAME: begin
        if (clk_rise) begin
          nxt_s.shift   = {s_ff.shift[22:0], data_s};
          if (s_ff.bit_cnt != 5'h1f) begin
            nxt_s.bit_cnt = 5'(s_ff.bit_cnt + 1'b1);
          end
        end
        // A frame without clock edges reloads a buffer from the old shift contents.
        if (frame_end) begin
          nxt_s.link     = LINK_IDLE;
          nxt_s.load_cnt = 8'(s_ff.load_cnt + 1'b1);
          // The unused buffers keep their contents, so the other word steers on.
          unique case (dest)
            2'b00: nxt_s.word_a = s_ff.shift[23:`WORD_LSB];
            2'b10: nxt_s.word_b = s_ff.shift[23:`WORD_LSB];
            2'b01: nxt_s.swallow = s_ff.shift[`FREQ_A_FIELD_LSB+3:`FREQ_A_FIELD_LSB];
            2'b11: nxt_s.refw = s_ff.shift[17:`WORD_LSB];
          endcase
        end
      end
    endcase

    // Wishbone slave: ack one cycle after the request, dropped in the next cycle.
    // A request is taken only while ack is low, so a held strobe gets an answer every second cycle.
    // Writes land on the edge at which the master sees ack, never earlier.
    nxt_s.ack = wb_req & ~s_ff.ack;
    if (wb_req & ~s_ff.ack) begin
      nxt_s.rdata = rd_mux;
    end
    if (wb_wr && wb_adr_i == `REG_CTRL_OFS && wb_sel_i[0]) begin
      nxt_s.power_down = wb_dat_i[`CTRL_PD_BIT];
    end

    // Divider controls from the active word.
    // The select pin may toggle in any cycle; the dividers follow three edges later, two of them in the synchroniser.
    nxt_s.m_out     = active.m_count;
    nxt_s.presc_out = s_ff.refw.prescaler_low;
    if (s_ff.refw.prescaler_low) begin
      nxt_s.a_out = {1'b0, active.a_count[2:0]};
    end else begin
      nxt_s.a_out = active.a_count;
    end

    // Gain table.
    // The pump 2 multiplier is kept in halves so that 1.5 and 2.5 stay exact.
    unique case ({active.gain_sel_hi, active.gain_sel_lo})
      2'b00: begin
        nxt_s.pump.cp1_current_ua = `CP1_UA_G00;
        nxt_s.pump.cp2_mult_x2    = `CP2_X2_G00;
      end
      2'b10: begin
        nxt_s.pump.cp1_current_ua = `CP1_UA_G10;
        nxt_s.pump.cp2_mult_x2    = `CP2_X2_G10;
      end
      2'b01: begin
        nxt_s.pump.cp1_current_ua = `CP1_UA_G01;
        nxt_s.pump.cp2_mult_x2    = `CP2_X2_G01;
      end
      2'b11: begin
        nxt_s.pump.cp1_current_ua = `CP1_UA_G11;
        nxt_s.pump.cp2_mult_x2    = `CP2_X2_G11;
      end
    endcase

    // Pump direction: sense 0 sources on RF lag.
    // Sense swaps the pins as well, so an external detector sees the same sense.
    nxt_s.pump.pump_source = ~active.sense;

    // Pump 1 is off with only the output bit set; lock may gate it.
    // Power-down stops both pumps but never the load path above.
    nxt_s.pump.cp1_on = ~s_ff.power_down
                        & ~(s_ff.refw.comp_output_enable & ~s_ff.refw.lock_gate_enable)
                        & ~(s_ff.refw.lock_gate_enable & lock_s);
    nxt_s.pump.cp2_on = ~s_ff.power_down;
    nxt_s.lock_n      = ~lock_s;

    // Comparison pins, swapped by the sense bit and gated by the enable.
    // An RF pulse passes straight through; only the reference is divided here.
    nxt_s.rf_pin  = comp_en & (active.sense ? ref_div : rf_tick);
    nxt_s.ref_pin = comp_en & (active.sense ? rf_tick : ref_div);
  end

  // State register with synchronous reset.
  // The reference word resets to ratio one, so the divider never stalls.
  // The lock indicator resets high: no lock is claimed before the comparator settles.
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      s_ff        <= '0;
      s_ff.link   <= LINK_IDLE;
      s_ff.word_a <= `FREQ_RESET;
      s_ff.word_b <= `FREQ_RESET;
      s_ff.refw   <= `REF_RESET;
      s_ff.lock_n <= 1'b1;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // Outputs straight from flip-flops.
  // Registered outputs keep synchroniser and decode glitches off the pins.
  assign wb_dat_o           = s_ff.rdata;
  assign wb_ack_o           = s_ff.ack;
  assign m_count            = s_ff.m_out;
  assign a_count            = s_ff.a_out;
  assign swallow_count_bits = s_ff.swallow;
  assign prescaler_low      = s_ff.presc_out;
  assign pump               = s_ff.pump;
  assign lock_indicator_n   = s_ff.lock_n;
  assign rf_divider_out     = s_ff.rf_pin;
  assign ref_divider_out    = s_ff.ref_pin;

  // Each clock rise inside a frame shifts one bit in at the bottom.
  property p_shift_in;
    @(posedge sys_clk) disable iff (reset)
    (s_ff.link == LINK_FRAME && clk_rise) |=> s_ff.shift == {$past(s_ff.shift[22:0]), $past(data_s)};
  endproperty
  a_shift_in: assert property (p_shift_in) else $error("Shift register did not take the bit MSB first.");

  // Code 00 loads word a on the edge after the frame closes.
  property p_load_a;
    @(posedge sys_clk) disable iff (reset)
    (frame_end && dest == 2'b00) |=> s_ff.word_a == $past(s_ff.shift[23:2]);
  endproperty
  a_load_a: assert property (p_load_a) else $error("Word a not loaded at enable fall.");

  // Code 11 loads the reference word and leaves word a alone.
  property p_load_ref;
    @(posedge sys_clk) disable iff (reset)
    (frame_end && dest == 2'b11) |=> s_ff.refw == $past(s_ff.shift[17:2]) && $stable(s_ff.word_a);
  endproperty
  a_load_ref: assert property (p_load_ref) else $error("Reference word load wrong.");

  // Only a closing frame may change a buffer; shifting never does.
  property p_hold;
    @(posedge sys_clk) disable iff (reset)
    !frame_end |=> $stable(s_ff.word_a) && $stable(s_ff.word_b) && $stable(s_ff.refw);
  endproperty
  a_hold: assert property (p_hold) else $error("Buffer changed outside a frame end.");

  // Select high puts the M count of word a on the divider.
  property p_select;
    @(posedge sys_clk) disable iff (reset)
    sel_s |=> m_count == $past(s_ff.word_a.m_count);
  endproperty
  a_select: assert property (p_select) else $error("Select high did not steer word a.");

  // Gain code 01 gives the 125 uA pump 1 current.
  property p_gain;
    @(posedge sys_clk) disable iff (reset)
    ({active.gain_sel_hi, active.gain_sel_lo} == 2'b01) |=> pump.cp1_current_ua == 8'h7d;
  endproperty
  a_gain: assert property (p_gain) else $error("Gain code 01 must give 125 uA.");

  // Pump direction follows the sense bit of the active word.
  property p_sense;
    @(posedge sys_clk) disable iff (reset)
    1'b1 |=> pump.pump_source == !$past(active.sense);
  endproperty
  a_sense: assert property (p_sense) else $error("Pump direction does not follow sense.");

  // The output bit alone switches pump 1 off.
  property p_cp1_off;
    @(posedge sys_clk) disable iff (reset)
    (s_ff.refw.comp_output_enable && !s_ff.refw.lock_gate_enable) |=> !pump.cp1_on;
  endproperty
  a_cp1_off: assert property (p_cp1_off) else $error("Pump 1 on with only output bit set.");

  // In lock with gating on, the indicator is low and pump 1 is off.
  property p_lock;
    @(posedge sys_clk) disable iff (reset)
    (lock_s && s_ff.refw.lock_gate_enable) |=> !lock_indicator_n && !pump.cp1_on;
  endproperty
  a_lock: assert property (p_lock) else $error("Lock did not pull indicator low and stop pump 1.");

  // Disabled comparison pins stay low.
  property p_comp_off;
    @(posedge sys_clk) disable iff (reset)
    !comp_en |=> !rf_divider_out && !ref_divider_out;
  endproperty
  a_comp_off: assert property (p_comp_off) else $error("Comparison pin active while disabled.");

  // The 8/9 pair leaves the top A count bit at zero.
  property p_a_three;
    @(posedge sys_clk) disable iff (reset)
    s_ff.refw.prescaler_low |=> !a_count[3];
  endproperty
  a_a_three: assert property (p_a_three) else $error("A count used four bits in 8/9 mode.");

  // Frames close only after the legal bit counts; a miscounting shift path trips this.
  property p_frame_len;
    @(posedge sys_clk) disable iff (reset)
    frame_end |-> s_ff.bit_cnt == ((dest == 2'b11) ? 5'h12 : 5'h18);
  endproperty
  a_frame_len: assert property (p_frame_len) else $error("Frame closed after a wrong bit count.");
endmodule
`default_nettype wire

// [bench/ser_ctrl_model.sv]
// Behavioural model of the controller that programs the block over the three-wire link.
`timescale 1ns/100ps
`default_nettype none
module ser_ctrl_model (
  input  wire logic sys_clk,
  output logic      ser_data,
  output logic      ser_clk,
  output logic      ser_enable
);
  // High while a frame is on the link.
  logic in_frame;

  // Quiet link at time zero: clock low, enable low.
  initial begin
    ser_data   = 1'b0;
    ser_clk    = 1'b0;
    ser_enable = 1'b0;
    in_frame   = 1'b0;
  end

  // Outside frames the data line is undriven, so it wanders every cycle to expose a
  // design that samples it when it should not.
  always @(posedge sys_clk) begin
    if (!in_frame) begin
      ser_data <= ~ser_data;
    end
  end

  // Sends the low n bits of w, top bit first, with a 160 ns link clock that stands
  // still between frames.
  task automatic send(input logic [23:0] w, input int n);
    @(posedge sys_clk);
    in_frame   <= 1'b1;
    ser_enable <= 1'b1;
    // Enable leads the first clock rise by several system cycles.
    repeat (8) @(posedge sys_clk);
    for (int i = n - 1; i >= 0; i--) begin
      @(posedge sys_clk);
      ser_data <= w[i];
      repeat (3) @(posedge sys_clk);
      ser_clk <= 1'b1;
      repeat (4) @(posedge sys_clk);
      ser_clk <= 1'b0;
    end
    repeat (4) @(posedge sys_clk);
    ser_enable <= 1'b0;
    in_frame   <= 1'b0;
    // Keep enable low well past the minimum gap between frames.
    repeat (8) @(posedge sys_clk);
  endtask
endmodule
`default_nettype wire

// [bench/tb_top.sv]
// Self-checking bench: random programming frames compared with a behavioural model.
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin \
  cmp_count++; \
  if ((g) !== (e)) begin \
    fail_count++; \
    $display("Error at %0t: got %h expected %h", $time, (g), (e)); \
  end \
end
module tb_top
  import synth_prog_pkg::*;
;
  logic        sys_clk = 1'b0;
  logic        reset = 1'b1;
  logic        wb_cyc_i = 1'b0;
  logic        wb_stb_i = 1'b0;
  logic        wb_we_i = 1'b0;
  logic [7:0]  wb_adr_i = 8'h00;
  logic [3:0]  wb_sel_i = 4'hf;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic        ser_data;
  logic        ser_clk;
  logic        ser_enable;
  logic        freq_word_select = 1'b1;
  logic        lock_window = 1'b0;
  logic        ref_osc = 1'b0;
  logic        rf_div_in = 1'b0;
  logic [14:0] m_count;
  logic [3:0]  a_count;
  logic [3:0]  swallow_count_bits;
  logic        prescaler_low;
  pump_ctrl_t  pump;
  logic        lock_indicator_n;
  logic        rf_divider_out;
  logic        ref_divider_out;
  // Model state: both frequency words, swallow, reference word and pin levels.
  logic [21:0] word_a_m = 22'h0;
  logic [21:0] word_b_m = 22'h0;
  logic [3:0]  swallow_m = 4'h0;
  logic [15:0] ref_m = 16'h0008;
  logic        sel_m = 1'b1;
  logic        lock_m = 1'b0;
  logic        pd_m = 1'b0;
  int          frames_m = 0;
  int          fail_count = 0;
  int          cmp_count = 0;
  int          seed = 32'hda365425;

  always #10 sys_clk = ~sys_clk;

  synth_prog dut (
    .sys_clk(sys_clk), .reset(reset), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .ser_data(ser_data), .ser_clk(ser_clk),
    .ser_enable(ser_enable), .freq_word_select(freq_word_select),
    .lock_window(lock_window), .ref_osc(ref_osc), .rf_div_in(rf_div_in),
    .m_count(m_count), .a_count(a_count), .swallow_count_bits(swallow_count_bits),
    .prescaler_low(prescaler_low), .pump(pump), .lock_indicator_n(lock_indicator_n),
    .rf_divider_out(rf_divider_out), .ref_divider_out(ref_divider_out)
  );

  ser_ctrl_model ctrl (
    .sys_clk(sys_clk), .ser_data(ser_data), .ser_clk(ser_clk), .ser_enable(ser_enable)
  );

  // Prints the counts and the verdict, then ends the run.
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // One classic bus cycle, held until the slave answers; only the watchdog ends a hang.
  task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [31:0] wd,
                         output logic [31:0] rd);
    @(posedge sys_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_sel_i <= 4'hf;
    wb_adr_i <= adr;
    wb_dat_i <= wd;
    do begin
      @(posedge sys_clk);
    end while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask

  // Expected pump controls from the active word, reference controls and lock state.
  function automatic pump_ctrl_t exp_pump(input logic [21:0] act);
    pump_ctrl_t p;
    p.cp1_on      = !pd_m && !(ref_m[2] && !ref_m[1]) && !(ref_m[1] && lock_m);
    p.cp2_on      = !pd_m;
    p.pump_source = !act[0];
    case (act[2:1])
      2'b00: begin p.cp1_current_ua = 8'h32; p.cp2_mult_x2 = 3'h2; end
      2'b10: begin p.cp1_current_ua = 8'h4b; p.cp2_mult_x2 = 3'h3; end
      2'b01: begin p.cp1_current_ua = 8'h7d; p.cp2_mult_x2 = 3'h5; end
      default: begin p.cp1_current_ua = 8'hc8; p.cp2_mult_x2 = 3'h0; end
    endcase
    return p;
  endfunction

  // Compares every output but the two comparison pins, and the readable buffers, with the model.
  task automatic check_all();
    logic [21:0] act;
    logic [31:0] rd;
    act = sel_m ? word_a_m : word_b_m;
    `CHK(m_count, act[21:7])
    `CHK(a_count, act[6:3] & {~ref_m[0], 3'h7})
    `CHK(swallow_count_bits, swallow_m)
    `CHK(prescaler_low, ref_m[0])
    `CHK(pump, exp_pump(act))
    `CHK(lock_indicator_n, ~lock_m)
    wb_xfer(1'b0, 8'h00, 32'h0, rd);
    `CHK(rd, {10'h0, word_a_m})
    wb_xfer(1'b0, 8'h04, 32'h0, rd);
    `CHK(rd, {10'h0, word_b_m})
    wb_xfer(1'b0, 8'h08, 32'h0, rd);
    `CHK(rd, {frames_m[7:0], 2'h0, lock_m, sel_m, swallow_m, ref_m})
    wb_xfer(1'b0, 8'h10, 32'h0, rd);
    `CHK(rd, 32'h0)
    wb_xfer(1'b0, 8'h0c, 32'h0, rd);
    `CHK(rd[0], pd_m)
  endtask

  // Sends one frame and mirrors its effect in the model.
  task automatic frame(input logic [23:0] f);
    // With the 8/9 pair the top A count bit must go out as zero.
    if (ref_m[0] && f[1:0] != 2'b11) begin
      f[8] = 1'b0;
    end
    ctrl.send(f, (f[1:0] == 2'b11) ? 18 : 24);
    frames_m++;
    case (f[1:0])
      2'b00: word_a_m = f[23:2];
      2'b10: word_b_m = f[23:2];
      2'b01: swallow_m = f[8:5];
      default: ref_m = f[17:2];
    endcase
    // Load lands a few edges after enable falls; the margin covers the synchronisers.
    repeat (8) @(posedge sys_clk);
  endtask

  // Random frames to every destination and every gain code, with select, lock and
  // power-down changing on the way.
  initial begin
    logic [31:0] r;
    logic [31:0] rd;
    logic [23:0] f;
    int          cnt_rf;
    int          cnt_ref;
    repeat (16) @(posedge sys_clk);
    reset <= 1'b0;
    repeat (4) @(posedge sys_clk);
    check_all();
    $display("test reset_values done");
    for (int i = 0; i < 20; i++) begin
      r = $random(seed);
      freq_word_select <= r[0];
      lock_window      <= r[1];
      sel_m  = r[0];
      lock_m = r[1];
      // Power-down spans several loads, which must still be accepted.
      if (i == 9 || i == 14) begin
        pd_m = (i == 9);
        wb_xfer(1'b1, 8'h0c, {31'h0, pd_m}, rd);
      end
      r = $random(seed);
      f = {r[23:5], i[3:2], r[2], i[1:0]};
      frame(f);
      check_all();
    end
    $display("test random_frames done");
    // Divider pulses reach the comparison pins only when enabled, routed by sense.
    r = $random(seed);
    frame({r[23:3], 1'b0, 2'b00});
    frame({r[23:3], 1'b1, 2'b10});
    for (int k = 0; k < 8; k++) begin
      frame({6'h0, 13'h0001, k[2], 2'b00, 2'b11});
      freq_word_select <= ~k[1];
      sel_m = ~k[1];
      repeat (8) @(posedge sys_clk);
      cnt_rf  = 0;
      cnt_ref = 0;
      for (int c = 0; c < 168; c++) begin
        @(posedge sys_clk);
        cnt_rf  += int'(rf_divider_out === 1'b1);
        cnt_ref += int'(ref_divider_out === 1'b1);
        if (k[0]) begin
          rf_div_in <= (c % 8 < 4) && (c < 160);
        end else begin
          ref_osc <= (c % 8 < 4) && (c < 160);
        end
      end
      // Twenty input rises at ratio one give twenty one-cycle pulses on one pin.
      `CHK(cnt_rf, (k[2] & (k[0] ^ k[1])) ? 20 : 0)
      `CHK(cnt_ref, (k[2] & ~(k[0] ^ k[1])) ? 20 : 0)
      check_all();
    end
    $display("test comparison_pins done");
    test_done();
  end

  // Watchdog well beyond the expected run length.
  initial begin
    repeat (60000) @(posedge sys_clk);
    fail_count++;
    test_done();
  end
endmodule
`default_nettype wire
